// ===== src/dmarr_top.sv
// Purpose: Address, count and request routing registers of a two-channel DMA unit.
// Assumes: AHB-Lite register access; channel-end strobes are one-cycle pulses on clk.
// Notes: Each register is one byte in the low lane of an aligned word.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "dmarr_map.svh"

module dmarr_top
    import dmarr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // AHB-Lite register bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Peripheral request lines and timer output.
    input wire dmarr_req_t periph_req,
    input wire logic timer_one_out,
    // Shared timer-output and request pin.
    input wire logic timer_out_request_pin_i,
    output logic timer_out_request_pin_o,
    output logic timer_out_request_pin_oe,
    // Channel-end strobes from the transfer sequencer.
    input wire logic ch0_end,
    input wire logic ch1_end,
    // Requests presented to the channels.
    output logic ch0_request,
    output logic ch1_request,
    // Address and count values for the sequencer.
    output logic [19:0] ch0_src_addr,
    output logic [19:0] ch0_dst_addr,
    output logic [19:0] ch1_mem_addr,
    output logic [15:0] ch1_count
);

    dmarr_wr_t wr;
    logic [5:0] rd_idx;
    logic [7:0] rd_value;

    // Register storage.
    logic [7:0] src_low_reg;
    logic [7:0] src_high_reg;
    logic [7:0] src_bank_reg;
    logic [7:0] dst_low_reg;
    logic [7:0] dst_high_reg;
    logic [7:0] dst_bank_reg;
    logic [7:0] mem_low_reg;
    logic [7:0] mem_high_reg;
    logic [7:0] mem_bank_reg;
    logic [7:0] cnt_low_reg;
    logic [7:0] cnt_high_reg;
    logic [7:0] sel_reg;
    logic flip_reg;
    logic [7:0] mode_reg;
    logic [7:0] ctrl_reg;

    // Output stages.
    logic ch0_request_reg;
    logic ch1_request_reg;
    logic pin_out_reg;

    // Router results.
    logic src_hit;
    logic dst_hit;
    logic ch1_hit;
    logic pin_req;

    // True when the current bus write targets the given register.
    function automatic logic wr_hit(input dmarr_wr_t w, input logic [5:0] idx);
        return w.en & (w.idx == idx);
    endfunction : wr_hit

    // Bus front end.
    dmarr_ahb_slave u_slave (
        .clk(clk),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr(wr),
        .rd_idx(rd_idx),
        .rd_value(rd_value)
    );

    // Write decode, one strobe per register.
    wire logic we_src_low = wr_hit(wr, `DMARR_IDX_SRC_LOW);
    wire logic we_src_high = wr_hit(wr, `DMARR_IDX_SRC_HIGH);
    wire logic we_src_bank = wr_hit(wr, `DMARR_IDX_SRC_BANK);
    wire logic we_dst_low = wr_hit(wr, `DMARR_IDX_DST_LOW);
    wire logic we_dst_high = wr_hit(wr, `DMARR_IDX_DST_HIGH);
    wire logic we_dst_bank = wr_hit(wr, `DMARR_IDX_DST_BANK);
    wire logic we_mem_low = wr_hit(wr, `DMARR_IDX_MEM_LOW);
    wire logic we_mem_high = wr_hit(wr, `DMARR_IDX_MEM_HIGH);
    wire logic we_mem_bank = wr_hit(wr, `DMARR_IDX_MEM_BANK);
    wire logic we_cnt_low = wr_hit(wr, `DMARR_IDX_CNT_LOW);
    wire logic we_cnt_high = wr_hit(wr, `DMARR_IDX_CNT_HIGH);
    wire logic we_sel = wr_hit(wr, `DMARR_IDX_REQ_SEL);
    wire logic we_mode = wr_hit(wr, `DMARR_IDX_MODE);
    wire logic we_ctrl = wr_hit(wr, `DMARR_IDX_CTRL);

    // Channel 0 source address bytes; only four bank bits are kept.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            src_low_reg <= `DMARR_RESET_BYTE;
            src_high_reg <= `DMARR_RESET_BYTE;
            src_bank_reg <= `DMARR_RESET_BYTE;
        end
        else
        begin
            if (we_src_low)
                src_low_reg <= wr.data;
            if (we_src_high)
                src_high_reg <= wr.data;
            if (we_src_bank)
                src_bank_reg <= wr.data & `DMARR_BANK_MASK;
        end
    end

    // Channel 0 destination address bytes.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dst_low_reg <= `DMARR_RESET_BYTE;
            dst_high_reg <= `DMARR_RESET_BYTE;
            dst_bank_reg <= `DMARR_RESET_BYTE;
        end
        else
        begin
            if (we_dst_low)
                dst_low_reg <= wr.data;
            if (we_dst_high)
                dst_high_reg <= wr.data;
            if (we_dst_bank)
                dst_bank_reg <= wr.data & `DMARR_BANK_MASK;
        end
    end

    // Channel 1 memory address bytes.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mem_low_reg <= `DMARR_RESET_BYTE;
            mem_high_reg <= `DMARR_RESET_BYTE;
            mem_bank_reg <= `DMARR_RESET_BYTE;
        end
        else
        begin
            if (we_mem_low)
                mem_low_reg <= wr.data;
            if (we_mem_high)
                mem_high_reg <= wr.data;
            if (we_mem_bank)
                mem_bank_reg <= wr.data & `DMARR_BANK_MASK;
        end
    end

    // Channel 1 byte count.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_low_reg <= `DMARR_RESET_BYTE;
            cnt_high_reg <= `DMARR_RESET_BYTE;
        end
        else
        begin
            if (we_cnt_low)
                cnt_low_reg <= wr.data;
            if (we_cnt_high)
                cnt_high_reg <= wr.data;
        end
    end

    // Selector, mode and control; reserved selector bits are not stored.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sel_reg <= `DMARR_RESET_BYTE;
            mode_reg <= `DMARR_RESET_BYTE;
            ctrl_reg <= `DMARR_RESET_BYTE;
        end
        else
        begin
            if (we_sel)
                sel_reg <= wr.data & `DMARR_SEL_MASK;
            if (we_mode)
                mode_reg <= wr.data & `DMARR_MODE_MASK;
            if (we_ctrl)
                ctrl_reg <= wr.data & `DMARR_CTRL_MASK;
        end
    end

    // Alternation flip-flop: channel ends win over a software write in the same cycle.
    wire logic share_on = sel_reg[`DMARR_SEL_SHARE];
    wire logic flip_set = share_on & ch0_end;
    wire logic flip_clr = share_on & ch1_end;
    wire logic flip_next = flip_set ? 1'b1 :
                           flip_clr ? 1'b0 :
                           we_sel ? wr.data[`DMARR_SEL_FLIP] : flip_reg;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            flip_reg <= 1'b0;
        else
            flip_reg <= flip_next;
    end

    // Mode fields and selection codes.
    wire logic src_mode_req = (mode_reg[`DMARR_MODE_SRC_HI:`DMARR_MODE_SRC_LO] == `DMARR_MODE_REQ);
    wire logic dst_mode_req = (mode_reg[`DMARR_MODE_DST_HI:`DMARR_MODE_DST_LO] == `DMARR_MODE_REQ);
    wire logic pin_is_output = sel_reg[`DMARR_SEL_DIR];
    wire logic dir_next = we_sel ? wr.data[`DMARR_SEL_DIR] : pin_is_output;
    wire logic ch1_io_mode_bit = ctrl_reg[`DMARR_CTRL_IO];

    // Request selection for both channels.
    dmarr_router u_router (
        .clk(clk),
        .resetn(resetn),
        .req(periph_req),
        .pin_in(timer_out_request_pin_i),
        .pin_is_output(pin_is_output),
        .src_code(src_bank_reg[2:0]),
        .dst_code(dst_bank_reg[2:0]),
        .ch1_code(sel_reg[2:0]),
        .ch1_io_mode_bit(ch1_io_mode_bit),
        .src_hit(src_hit),
        .dst_hit(dst_hit),
        .ch1_hit(ch1_hit),
        .pin_req(pin_req)
    );

    // Channel 0 takes its source request, else its destination request, else the pin.
    wire logic ch0_raw = src_mode_req ? src_hit : (dst_mode_req ? dst_hit : pin_req);
    // Sharing hides the request from the channel that the flip-flop does not point at.
    wire logic ch0_gated = ch0_raw & ~(share_on & flip_reg);
    wire logic ch1_gated = ch1_hit & ~(share_on & ~flip_reg);

    // Registered requests and pin drive.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ch0_request_reg <= 1'b0;
            ch1_request_reg <= 1'b0;
            pin_out_reg <= 1'b0;
        end
        else
        begin
            ch0_request_reg <= ch0_gated;
            ch1_request_reg <= ch1_gated;
            pin_out_reg <= dir_next & timer_one_out;
        end
    end

    // Read multiplexer; unmapped indices read zero.
    assign rd_value =
        (rd_idx == `DMARR_IDX_SRC_LOW) ? src_low_reg :
        (rd_idx == `DMARR_IDX_SRC_HIGH) ? src_high_reg :
        (rd_idx == `DMARR_IDX_SRC_BANK) ? src_bank_reg :
        (rd_idx == `DMARR_IDX_DST_LOW) ? dst_low_reg :
        (rd_idx == `DMARR_IDX_DST_HIGH) ? dst_high_reg :
        (rd_idx == `DMARR_IDX_DST_BANK) ? dst_bank_reg :
        (rd_idx == `DMARR_IDX_MEM_LOW) ? mem_low_reg :
        (rd_idx == `DMARR_IDX_MEM_HIGH) ? mem_high_reg :
        (rd_idx == `DMARR_IDX_MEM_BANK) ? mem_bank_reg :
        (rd_idx == `DMARR_IDX_CNT_LOW) ? cnt_low_reg :
        (rd_idx == `DMARR_IDX_CNT_HIGH) ? cnt_high_reg :
        (rd_idx == `DMARR_IDX_REQ_SEL) ? {sel_reg[7], flip_reg, sel_reg[5:0]} :
        (rd_idx == `DMARR_IDX_MODE) ? mode_reg :
        (rd_idx == `DMARR_IDX_CTRL) ? ctrl_reg : `DMARR_RESET_BYTE;

    // Outputs straight from the registers.
    assign ch0_src_addr = {src_bank_reg[3:0], src_high_reg, src_low_reg};
    assign ch0_dst_addr = {dst_bank_reg[3:0], dst_high_reg, dst_low_reg};
    assign ch1_mem_addr = {mem_bank_reg[3:0], mem_high_reg, mem_low_reg};
    assign ch1_count = {cnt_high_reg, cnt_low_reg};
    assign ch0_request = ch0_request_reg;
    assign ch1_request = ch1_request_reg;
    assign timer_out_request_pin_o = pin_out_reg;
    assign timer_out_request_pin_oe = pin_is_output;

endmodule : dmarr_top
`default_nettype wire

// ===== src/dmarr_map.svh
// Purpose: Register indices, field positions and codes of the DMA request routing block.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
`ifndef DMARR_MAP_SVH
`define DMARR_MAP_SVH

// Register indices.
`define DMARR_IDX_SRC_LOW 6'h20
`define DMARR_IDX_SRC_HIGH 6'h21
`define DMARR_IDX_SRC_BANK 6'h22
`define DMARR_IDX_DST_LOW 6'h23
`define DMARR_IDX_DST_HIGH 6'h24
`define DMARR_IDX_DST_BANK 6'h25
`define DMARR_IDX_MEM_LOW 6'h28
`define DMARR_IDX_MEM_HIGH 6'h29
`define DMARR_IDX_MEM_BANK 6'h2a
`define DMARR_IDX_REQ_SEL 6'h2d
`define DMARR_IDX_CNT_LOW 6'h2e
`define DMARR_IDX_CNT_HIGH 6'h2f
`define DMARR_IDX_MODE 6'h31
`define DMARR_IDX_CTRL 6'h32
`define DMARR_IDX_NONE 6'h00

// Implemented bit masks and reset value.
`define DMARR_BANK_MASK 8'h0f
`define DMARR_SEL_MASK 8'hcf
`define DMARR_MODE_MASK 8'h3c
`define DMARR_CTRL_MASK 8'h02
`define DMARR_RESET_BYTE 8'h00

// Field positions.
`define DMARR_SEL_SHARE 7
`define DMARR_SEL_FLIP 6
`define DMARR_SEL_DIR 3
`define DMARR_CTRL_IO 1
`define DMARR_MODE_DST_HI 5
`define DMARR_MODE_DST_LO 4
`define DMARR_MODE_SRC_HI 3
`define DMARR_MODE_SRC_LO 2

// Field codes.
`define DMARR_MODE_REQ 2'h3
`define DMARR_CODE_PIN 3'h0
`define DMARR_CODE_ASYNC0 3'h1
`define DMARR_CODE_ASYNC1 3'h2
`define DMARR_CODE_SYNC 3'h3
`define DMARR_CODE_PAR 3'h7
`define DMARR_HSIZE_WORD 3'h2
`define DMARR_ADDR_HIGH_ZERO 24'h000000
`define DMARR_RDATA_PAD 24'h000000

`endif

// ===== src/dmarr_pkg.sv
// Purpose: Types shared by the DMA request routing block.
// Assumes: Nothing beyond the map header.
// Notes: Types only.
package dmarr_pkg;

    // Request lines from the on-chip peripherals.
    typedef struct packed {
        logic async0_rx;
        logic async0_tx;
        logic async1_rx;
        logic async1_tx;
        logic sync_rx;
        logic sync_tx;
        logic par_in;
        logic par_out;
    } dmarr_req_t;

    // One register write from the bus slave.
    typedef struct packed {
        logic en;
        logic [5:0] idx;
        logic [7:0] data;
    } dmarr_wr_t;

endpackage : dmarr_pkg

// ===== src/dmarr_ahb_slave.sv
// Purpose: AHB-Lite slave front end of the DMA request routing block.
// Assumes: Single word transfers; one slave on the bus.
// Notes: Writes take no wait state, reads take one.
`timescale 1ns/100ps
`default_nettype none
`include "dmarr_map.svh"

module dmarr_ahb_slave
    import dmarr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // AHB-Lite bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register file side.
    output dmarr_wr_t wr,
    output logic [5:0] rd_idx,
    input wire logic [7:0] rd_value
);

    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [5:0] idx_reg;
    logic ready_reg;
    logic [31:0] rdata_reg;

    // Address phase decode; addresses above the map fall on the unmapped index.
    wire logic take = hsel & htrans[1] & hready & (hsize == `DMARR_HSIZE_WORD);
    wire logic in_map = (haddr[31:8] == `DMARR_ADDR_HIGH_ZERO);
    wire logic [5:0] idx_next = in_map ? haddr[7:2] : `DMARR_IDX_NONE;

    // Capture the address phase; a read stalls one cycle while its byte is registered onto hrdata.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= `DMARR_IDX_NONE;
            ready_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            wr_pend_reg <= take & hwrite;
            rd_pend_reg <= take & ~hwrite;
            ready_reg <= ~(take & ~hwrite);
            if (take)
                idx_reg <= idx_next;
            if (rd_pend_reg)
                rdata_reg <= {`DMARR_RDATA_PAD, rd_value};
        end
    end

    // Write strobe during the data phase, with data straight from the bus.
    assign wr.en = wr_pend_reg;
    assign wr.idx = idx_reg;
    assign wr.data = hwdata[7:0];
    assign rd_idx = idx_reg;
    assign hreadyout = ready_reg;
    assign hrdata = rdata_reg;
    assign hresp = 1'b0; // Always OKAY.

endmodule : dmarr_ahb_slave
`default_nettype wire

// ===== src/dmarr_router.sv
// Purpose: Request selection for both DMA channels.
// Assumes: Peripheral requests share the clock; the pin does not.
// Notes: Outputs are combinational and registered by the caller.
`timescale 1ns/100ps
`default_nettype none
`include "dmarr_map.svh"

module dmarr_router
    import dmarr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Request sources.
    input wire dmarr_req_t req,
    input wire logic pin_in,
    input wire logic pin_is_output,
    // Selection codes.
    input wire logic [2:0] src_code,
    input wire logic [2:0] dst_code,
    input wire logic [2:0] ch1_code,
    input wire logic ch1_io_mode_bit,
    // Selected requests.
    output logic src_hit,
    output logic dst_hit,
    output logic ch1_hit,
    output logic pin_req
);

    logic pin_meta_reg;
    logic pin_sync_reg;

    // Maps a code to a request; rx picks receive side, extra joins code 010 on the receive side only.
    function automatic logic pick(input logic [2:0] code, input logic rx, input dmarr_req_t r,
                                  input logic pin, input logic extra);
        logic hit;
        hit = 1'b0;
        case (code)
            `DMARR_CODE_PIN: hit = pin;
            `DMARR_CODE_ASYNC0: hit = rx ? r.async0_rx : r.async0_tx;
            `DMARR_CODE_ASYNC1: hit = rx ? (r.async1_rx | extra) : r.async1_tx;
            `DMARR_CODE_SYNC: hit = rx ? r.sync_rx : r.sync_tx;
            `DMARR_CODE_PAR: hit = rx ? r.par_in : r.par_out;
            default: hit = 1'b0; // Reserved codes route nothing.
        endcase
        return hit;
    endfunction : pick

    // Two-stage synchroniser for the shared pin.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // The pin is a request only while it is an input.
    assign pin_req = pin_sync_reg & ~pin_is_output;

    // Channel 0 source side uses receive requests, destination side transmit requests.
    assign src_hit = pick(src_code, 1'b1, req, pin_req, 1'b0);
    assign dst_hit = pick(dst_code, 1'b0, req, pin_req, 1'b0);
    // Channel 1 follows the I/O mode bit; 010 in receive mode also takes the pin.
    assign ch1_hit = pick(ch1_code, ch1_io_mode_bit, req, pin_req, pin_req);

endmodule : dmarr_router
`default_nettype wire

// ===== tb/dmarr_top_chk.sv
// Purpose: Bus, pin and reset timing checker for the request routing block.
// Assumes: One clock; reset is synchronous and active low.
// Notes: Bound to every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
module dmarr_top_chk
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Bus.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pin and requests.
    input wire logic timer_one_out,
    input wire logic timer_out_request_pin_o,
    input wire logic timer_out_request_pin_oe,
    input wire logic ch0_request,
    input wire logic ch1_request
);
    // Every check samples on clk and rests while reset is low.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Word transfers accepted by the slave, and the single wait of a read.
    sequence s_rd;
        hsel && htrans[1] && hready && hsize == 3'h2 && !hwrite;
    endsequence
    sequence s_wr;
        hsel && htrans[1] && hready && hsize == 3'h2 && hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_one_wait: assert property (s_rd |=> s_one_wait)
        else $error("read did not take exactly one wait cycle");
    a_write_no_wait: assert property (s_wr |=> hreadyout)
        else $error("write inserted a wait cycle");
    a_wait_ends: assert property (!hreadyout |=> hreadyout)
        else $error("wait lasted more than one cycle");
    a_rdata_pad: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
        else $error("read data changed outside a read");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response was not okay");
    a_pin_idle_low: assert property (!timer_out_request_pin_oe |-> !timer_out_request_pin_o)
        else $error("pin output active while pin is an input");
    a_pin_timer: assert property (timer_out_request_pin_oe && $past(timer_out_request_pin_oe)
        |-> timer_out_request_pin_o == $past(timer_one_out))
        else $error("pin output does not follow the timer");
    a_reset_quiet: assert property (!$past(resetn)
        |-> !ch0_request && !ch1_request && !timer_out_request_pin_oe)
        else $error("outputs not cleared by reset");
endmodule : dmarr_top_chk

bind dmarr_top dmarr_top_chk chk_u (.clk(clk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_one_out(timer_one_out), .timer_out_request_pin_o(timer_out_request_pin_o),
    .timer_out_request_pin_oe(timer_out_request_pin_oe), .ch0_request(ch0_request), .ch1_request(ch1_request));
`default_nettype wire

// ===== tb/dmarr_periph_model.sv
// Purpose: Peripherals, timer and external requester around the routing block.
// Assumes: The bench commands the request levels.
// Notes: The timer runs a random level every cycle.
`timescale 1ns/100ps
`default_nettype none
module dmarr_periph_model
    import dmarr_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Levels commanded by the bench.
    input wire dmarr_req_t want_req,
    input wire logic want_pin,
    // Block side of the shared pin.
    input wire logic pin_o,
    input wire logic pin_oe,
    // Lines into the block.
    output var dmarr_req_t periph_req,
    output var logic timer_one_out,
    output logic pin_i
);
    // Start quiet at time zero.
    initial
    begin
        periph_req = '0;
        timer_one_out = 1'b0;
    end
    // Peripherals change their levels just after the edge.
    always @(posedge clk)
    begin
        periph_req <= want_req;
        timer_one_out <= 1'($urandom % 2);
    end
    // The wire carries the block's level while it drives, else the requester's.
    assign pin_i = pin_oe ? pin_o : want_pin;
endmodule : dmarr_periph_model
`default_nettype wire

// ===== tb/tb_dmarr_top.sv
// Purpose: Self-checking bench for the DMA request routing block.
// Assumes: One AHB-Lite master; the peripheral model holds the far side.
// Notes: Reads are checked from a queue by a monitor process.
`timescale 1ns/100ps
`default_nettype none
module tb_dmarr_top
    import dmarr_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rdp = 1'b0;
    logic ch0_end = 1'b0;
    logic ch1_end = 1'b0;
    logic want_pin = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    dmarr_req_t want_req = '0;
    dmarr_req_t periph_req;
    logic hready, hreadyout, hresp, timer_one_out, pin_i, pin_o, pin_oe, ch0_request, ch1_request;
    logic [31:0] hrdata;
    logic [19:0] ch0_src_addr, ch0_dst_addr, ch1_mem_addr;
    logic [15:0] ch1_count;
    logic [7:0] oh;
    logic [7:0] val [64];
    logic [7:0] expq [$];
    int errors = 0;
    int check_count = 0;
    // Registers walked by the readback test and their implemented bits.
    logic [5:0] ix [11] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h28, 6'h29, 6'h2a, 6'h2e, 6'h2f};
    logic [7:0] mk [11] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};
    // Request codes and the receive lane each one selects.
    logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    int rx [5] = '{0, 7, 5, 3, 1};

    // Clock and the single slave's ready.
    always #2 clk = ~clk;
    assign hready = hreadyout;

    dmarr_top dut_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .periph_req(periph_req), .timer_one_out(timer_one_out), .timer_out_request_pin_i(pin_i),
        .timer_out_request_pin_o(pin_o), .timer_out_request_pin_oe(pin_oe), .ch0_end(ch0_end),
        .ch1_end(ch1_end), .ch0_request(ch0_request), .ch1_request(ch1_request), .ch0_src_addr(ch0_src_addr),
        .ch0_dst_addr(ch0_dst_addr), .ch1_mem_addr(ch1_mem_addr), .ch1_count(ch1_count));
    dmarr_periph_model model_u (.clk(clk), .want_req(want_req), .want_pin(want_pin), .pin_o(pin_o),
        .pin_oe(pin_oe), .periph_req(periph_req), .timer_one_out(timer_one_out), .pin_i(pin_i));

    // Compares a seen value with an expected one and counts both outcomes.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // Waits for ready at a rising edge, giving up after a bounded count.
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hready !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            errors++;
            summarize();
        end
    endtask : wait_ready

    // One single word transfer; upper write lanes carry noise the slave must ignore.
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, idx, 2'h0};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {$urandom} & 32'hffffff00 | {24'h0, d};
        rdp <= !w;
        wait_ready();
        rdp <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask : wr

    // A read notes its expected byte before the bus cycle starts.
    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        expq.push_back(e);
        xfer(1'b0, idx, 8'h00);
    endtask : rd

    // Pulses the channel ends for one cycle and checks the routed requests.
    task automatic pulse(input logic a, input logic b, input logic e0, input logic e1);
        ch0_end <= a;
        ch1_end <= b;
        @(posedge clk);
        ch0_end <= 1'b0;
        ch1_end <= 1'b0;
        repeat (3) @(posedge clk);
        check(ch0_request, e0);
        check(ch1_request, e1);
    endtask : pulse

    // Takes the oldest noted byte when a read completes.
    always @(posedge clk)
        if (rdp && hready)
            check(hrdata, {24'h0, expq.pop_front()});

    // Main sequence.
    initial
    begin
        void'($urandom(32'hd2f4efc6));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rd(6'h2d, 8'h00);
        rd(6'h20, 8'h00);
        for (int i = 0; i < 11; i++)
        begin
            val[ix[i]] = 8'($urandom);
            wr(ix[i], val[ix[i]]);
            rd(ix[i], val[ix[i]] & mk[i]);
        end
        check(ch0_src_addr, {val[6'h22][3:0], val[6'h21], val[6'h20]});
        check(ch0_dst_addr, {val[6'h25][3:0], val[6'h24], val[6'h23]});
        check(ch1_mem_addr, {val[6'h2a][3:0], val[6'h29], val[6'h28]});
        check(ch1_count, {val[6'h2f], val[6'h2e]});
        wr(6'h3f, 8'($urandom));
        rd(6'h3f, 8'h00);
        $display("test readback done");
        for (int m = 0; m < 4; m++)
            for (int i = 0; i < 5; i++)
            begin
                wr(6'h31, m == 0 ? 8'h0c : (m == 1 ? 8'h30 : 8'h00));
                wr(6'h32, m == 3 ? 8'h02 : 8'h00);
                wr(m == 0 ? 6'h22 : (m == 1 ? 6'h25 : 6'h2d), {5'h0, cd[i]});
                oh = (i == 0) ? 8'h00 : 8'h01 << (rx[i] - (m == 1 || m == 2));
                for (int h = 0; h < 2; h++)
                begin
                    want_req <= h ? ~oh : oh;
                    want_pin <= (i == 0) ^ h;
                    repeat (4) @(posedge clk);
                    check(m < 2 ? ch0_request : ch1_request, !h || (m == 3 && i == 2));
                end
            end
        $display("test routing done");
        wr(6'h31, 8'h0c);
        wr(6'h32, 8'h02);
        wr(6'h22, 8'h01);
        wr(6'h2d, 8'h81);
        want_req <= 8'h80;
        want_pin <= 1'b0;
        pulse(1'b0, 1'b0, 1'b1, 1'b0);
        pulse(1'b1, 1'b0, 1'b0, 1'b1);
        rd(6'h2d, 8'hc1);
        pulse(1'b0, 1'b1, 1'b1, 1'b0);
        pulse(1'b1, 1'b1, 1'b0, 1'b1);
        wr(6'h2d, 8'h01);
        pulse(1'b1, 1'b0, 1'b1, 1'b1);
        rd(6'h2d, 8'h01);
        $display("test sharing done");
        want_req <= 8'h00;
        want_pin <= 1'b1;
        wr(6'h2d, 8'h08);
        repeat (12) @(posedge clk);
        check(pin_oe, 1'b1);
        check(ch1_request, 1'b0);
        rd(6'h2d, 8'h08);
        wr(6'h2d, 8'h00);
        repeat (4) @(posedge clk);
        check(pin_oe, 1'b0);
        check(ch1_request, 1'b1);
        $display("test pin done");
        summarize();
    end
endmodule : tb_dmarr_top
`default_nettype wire
